// >>> design/rivm_map.svh
// vector numbering, base word addresses and placement constants
`ifndef RIVM_MAP_SVH
`define RIVM_MAP_SVH
`define RIVM_ADDR_W 13
`define RIVM_RESET_ADDR 13'h0000
`define RIVM_VEC_BASE 13'h0002
`define RIVM_VEC_STRIDE 13'h0002
`define RIVM_NUM_IRQ 20
`define RIVM_IDX_W 5
`define RIVM_FUSE_PROG 1'b0
`define RIVM_UNLOCK_CYCLES 3'h4
`define RIVM_BOOT_SZ_W 2
// boot start per size code 00..11, word addresses
`define RIVM_BOOT_START_0 13'h1800
`define RIVM_BOOT_START_1 13'h1c00
`define RIVM_BOOT_START_2 13'h1e00
`define RIVM_BOOT_START_3 13'h1f00
`endif

// >>> design/rivm_pkg.sv
// types for the reset and interrupt vector address logic
package rivm_pkg;
    typedef enum logic [1:0] {
        RIVM_IDLE,
        RIVM_OPEN
    } rivm_unlock_t;
endpackage

// >>> design/rivm_sync.sv
// two-flop synchroniser for one asynchronous level
module rivm_sync (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1_ff;
    logic stage2_ff;
    logic nxt_stage1;
    logic nxt_stage2;

    // stage one feeds only stage two
    always_comb begin
        nxt_stage1 = async_in;
        nxt_stage2 = stage1_ff;
    end

    // both stages clear together, so a fuse reads programmed until synced
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    assign sync_out = stage2_ff;
endmodule

// >>> design/rivm_vector_map.sv
// reset entry and interrupt vector address selection for the core
// Operation
// - every reset cause starts at word zero unless the boot fuse is programmed
// - external requests vector to 002, 004, 024
// - wide timer events vector 00a to 010
// - eight-bit timers vector 006, 008, 012, 026
// - serial events vector 014 to 01a, 022
// - adc, eeprom, comparator, store vectors 01c-028
// - programmed boot fuse moves reset to boot
// - select bit adds boot start to vectors
// - four fuse and select placement combinations
// - vector fetched only when interrupt taken
// - select change needs unlock within four cycles
// - boot start follows boot size fuses
`include "rivm_map.svh"
module rivm_vector_map
    import rivm_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic boot_reset_fuse,
    input wire logic [1:0] boot_section_size_fuses,
    input wire logic core_reset_pending,
    input wire logic ctrl_write,
    input wire logic ctrl_unlock_wdata,
    input wire logic ctrl_select_wdata,
    input wire logic irq_enable_global,
    input wire logic irq_ack,
    input wire logic ext_request_zero,
    input wire logic ext_request_one,
    input wire logic timer_b_compare_event,
    input wire logic timer_b_overflow_event,
    input wire logic wide_timer_capture_event,
    input wire logic wide_timer_compare_a_event,
    input wire logic wide_timer_compare_b_event,
    input wire logic wide_timer_overflow_event,
    input wire logic timer_a_overflow_event,
    input wire logic spi_transfer_done,
    input wire logic serial_receive_done,
    input wire logic serial_tx_buffer_empty,
    input wire logic serial_transmit_done,
    input wire logic adc_conversion_done,
    input wire logic eeprom_write_ready,
    input wire logic comparator_event,
    input wire logic two_wire_event,
    input wire logic ext_request_two,
    input wire logic timer_a_compare_event,
    input wire logic program_store_ready,
    output logic pc_load,
    output logic [12:0] pc_load_addr,
    output logic [4:0] taken_index,
    output logic vector_place_select,
    output logic vector_change_unlock
);
    localparam int NIRQ = `RIVM_NUM_IRQ;

    logic [NIRQ-1:0] req;
    logic fuse_sync;
    logic [1:0] size_sync;
    logic [12:0] boot_start;
    logic found;
    logic [4:0] win;

    // fuses arrive as pin levels, so each passes two flops first
    rivm_sync u_sync_fuse (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(boot_reset_fuse),
        .sync_out(fuse_sync)
    );
    rivm_sync u_sync_sz0 (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(boot_section_size_fuses[0]),
        .sync_out(size_sync[0])
    );
    rivm_sync u_sync_sz1 (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(boot_section_size_fuses[1]),
        .sync_out(size_sync[1])
    );

    // request vector in table order: bit i is vector number i+2
    assign req = {program_store_ready, timer_a_compare_event,
                  ext_request_two, two_wire_event,
                  comparator_event, eeprom_write_ready,
                  adc_conversion_done, serial_transmit_done,
                  serial_tx_buffer_empty, serial_receive_done,
                  spi_transfer_done, timer_a_overflow_event,
                  wide_timer_overflow_event, wide_timer_compare_b_event,
                  wide_timer_compare_a_event,
                  wide_timer_capture_event,
                  timer_b_overflow_event, timer_b_compare_event,
                  ext_request_one, ext_request_zero};

    // boot section start from size code
    always_comb begin
        unique case (size_sync)
            2'h0: boot_start = `RIVM_BOOT_START_0;
            2'h1: boot_start = `RIVM_BOOT_START_1;
            2'h2: boot_start = `RIVM_BOOT_START_2;
            2'h3: boot_start = `RIVM_BOOT_START_3;
        endcase
    end

    // fixed priority: scan from the top so the lowest index wins
    always_comb begin
        found = 1'b0;
        win = 5'h00;
        for (int i = NIRQ - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                win = 5'(i);
            end
        end
    end

    // unlock sequence for the placement select bit
    rivm_unlock_t state_ff, nxt_state;
    logic open_ff, nxt_open;
    logic [2:0] win_cnt_ff, nxt_win_cnt;
    logic sel_ff, nxt_sel;

    always_comb begin
        nxt_state = state_ff;
        nxt_win_cnt = win_cnt_ff;
        nxt_sel = sel_ff;
        unique case (state_ff)
            RIVM_IDLE: begin
                if (ctrl_write && ctrl_unlock_wdata) begin
                    nxt_state = RIVM_OPEN;
                    nxt_win_cnt = `RIVM_UNLOCK_CYCLES;
                end
            end
            RIVM_OPEN: begin
                if (ctrl_write && !ctrl_unlock_wdata) begin
                    nxt_sel = ctrl_select_wdata;
                    nxt_state = RIVM_IDLE;
                    nxt_win_cnt = 3'h0;
                end else if (ctrl_write) begin
                    nxt_win_cnt = `RIVM_UNLOCK_CYCLES;
                end else if (win_cnt_ff == 3'h1) begin
                    // late write would be ignored: window closes
                    nxt_state = RIVM_IDLE;
                    nxt_win_cnt = 3'h0;
                end else begin
                    nxt_win_cnt = win_cnt_ff - 3'h1;
                end
            end
        endcase
        // window flag has its own flop so the output is registered
        nxt_open = (nxt_state == RIVM_OPEN);
    end

    // state, window count and select bit registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= RIVM_IDLE;
            win_cnt_ff <= 3'h0;
            sel_ff <= 1'b0;
            open_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            win_cnt_ff <= nxt_win_cnt;
            sel_ff <= nxt_sel;
            open_ff <= nxt_open;
        end
    end

    // program counter load
    logic load_ff, nxt_load;
    logic [12:0] addr_ff, nxt_addr;
    logic [4:0] idx_ff, nxt_idx;
    logic busy_ff, nxt_busy;

    // reset entry has priority; one interrupt vector per ack
    always_comb begin
        nxt_load = 1'b0;
        nxt_addr = addr_ff;
        nxt_idx = idx_ff;
        nxt_busy = busy_ff && !irq_ack;
        if (core_reset_pending) begin
            nxt_load = 1'b1;
            nxt_idx = 5'h00;
            nxt_busy = 1'b0;
            if (fuse_sync == `RIVM_FUSE_PROG) begin
                nxt_addr = boot_start;
            end else begin
                nxt_addr = `RIVM_RESET_ADDR;
            end
        end else if (found && irq_enable_global && !busy_ff) begin
            // only a taken interrupt fetches its slot
            nxt_load = 1'b1;
            nxt_busy = 1'b1;
            nxt_idx = win;
            nxt_addr = `RIVM_VEC_BASE
                + 13'(win) * `RIVM_VEC_STRIDE
                + (sel_ff ? boot_start : 13'h0000);
        end
    end

    // load pulse and held address and index; address keeps its last value
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            load_ff <= 1'b0;
            addr_ff <= `RIVM_RESET_ADDR;
            idx_ff <= 5'h00;
            busy_ff <= 1'b0;
        end else begin
            load_ff <= nxt_load;
            addr_ff <= nxt_addr;
            idx_ff <= nxt_idx;
            busy_ff <= nxt_busy;
        end
    end

    assign pc_load = load_ff;
    assign pc_load_addr = addr_ff;
    assign taken_index = idx_ff;
    assign vector_place_select = sel_ff;
    assign vector_change_unlock = open_ff;

    // checks compare against the values the load was computed from
    AST_RESET_ADDR: assert property (
        @(posedge mclk) disable iff (!resetn)
        core_reset_pending |=> pc_load && pc_load_addr ==
            ($past(fuse_sync) ? `RIVM_RESET_ADDR : $past(boot_start)))
        else $error("reset entry address wrong");
    AST_VEC_ADDR: assert property (
        @(posedge mclk) disable iff (!resetn)
        pc_load && !$past(core_reset_pending) |-> pc_load_addr ==
            `RIVM_VEC_BASE + 13'(taken_index) * `RIVM_VEC_STRIDE
            + ($past(vector_place_select) ? $past(boot_start) : 13'h0000))
        else $error("vector address wrong");
    AST_LOWEST_WINS: assert property (
        @(posedge mclk) disable iff (!resetn)
        !core_reset_pending && irq_enable_global && !busy_ff && req[0]
        |=> pc_load && taken_index == 5'h00)
        else $error("lowest vector not chosen");
    AST_NO_FETCH: assert property (
        @(posedge mclk) disable iff (!resetn)
        !core_reset_pending && !(found && irq_enable_global)
        |=> !pc_load)
        else $error("fetch without taken interrupt");
    AST_LOCKED_SEL: assert property (
        @(posedge mclk) disable iff (!resetn)
        !vector_change_unlock |=>
            vector_place_select == $past(vector_place_select))
        else $error("select changed without unlock");
    AST_WINDOW_LEN: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(vector_change_unlock) ##0 (!ctrl_write) [*4]
        |=> !vector_change_unlock)
        else $error("unlock window too long");
    AST_BOOT_FUSE: assert property (
        @(posedge mclk) disable iff (!resetn)
        core_reset_pending && !fuse_sync |=>
            pc_load_addr == $past(boot_start)
            && pc_load_addr != `RIVM_RESET_ADDR)
        else $error("boot reset not applied");
    AST_EXT_TWO: assert property (
        @(posedge mclk) disable iff (!resetn)
        pc_load && taken_index == 5'h11 && !$past(vector_place_select)
        && !$past(core_reset_pending) |-> pc_load_addr == 13'h0024)
        else $error("request two vector wrong");
endmodule

// >>> sim/rivm_core_model.sv
// core-side model: answers each vector load with a handler-done pulse
module rivm_core_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic pc_load,
    input wire logic [3:0] ack_delay,
    output logic irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // a long delay keeps the block busy, so refused requests show up;
    // one process owns irq_ack so it has a single driver
    initial begin
        irq_ack = 1'b0;
        forever begin
            @(posedge mclk);
            if (resetn === 1'b1 && pc_load === 1'b1) begin
                repeat (ack_delay) @(posedge mclk);
                irq_ack <= 1'b1;
                @(posedge mclk);
                irq_ack <= 1'b0;
            end
        end
    end
endmodule

// >>> sim/reset_irq_vector_address_map_tb.sv
// self-checking bench for the vector address logic
`include "rivm_map.svh"
module reset_irq_vector_address_map_tb
    import rivm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, resetn, fuse, rp, cw, cu, cs, gie;
    logic [1:0] sz;
    logic [19:0] r;
    logic [3:0] dly;
    logic pl, sel, unl, ack;
    logic [12:0] ad;
    logic [4:0] ix;
    int errors, total_checks, cycles;
    rivm_vector_map dut (.mclk(mclk), .resetn(resetn),
        .boot_reset_fuse(fuse), .boot_section_size_fuses(sz),
        .core_reset_pending(rp), .ctrl_write(cw), .ctrl_unlock_wdata(cu),
        .ctrl_select_wdata(cs), .irq_enable_global(gie), .irq_ack(ack),
        .ext_request_zero(r[0]), .ext_request_one(r[1]),
        .timer_b_compare_event(r[2]), .timer_b_overflow_event(r[3]),
        .wide_timer_capture_event(r[4]), .wide_timer_compare_a_event(r[5]),
        .wide_timer_compare_b_event(r[6]), .wide_timer_overflow_event(r[7]),
        .timer_a_overflow_event(r[8]), .spi_transfer_done(r[9]),
        .serial_receive_done(r[10]), .serial_tx_buffer_empty(r[11]),
        .serial_transmit_done(r[12]), .adc_conversion_done(r[13]),
        .eeprom_write_ready(r[14]), .comparator_event(r[15]),
        .two_wire_event(r[16]), .ext_request_two(r[17]),
        .timer_a_compare_event(r[18]), .program_store_ready(r[19]),
        .pc_load(pl), .pc_load_addr(ad), .taken_index(ix),
        .vector_place_select(sel), .vector_change_unlock(unl));
    rivm_core_model core (.mclk(mclk), .resetn(resetn), .pc_load(pl),
        .ack_delay(dly), .irq_ack(ack));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 4000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [12:0] bs(input int c);
        case (c)
            0: return `RIVM_BOOT_START_0;
            1: return `RIVM_BOOT_START_1;
            2: return `RIVM_BOOT_START_2;
            default: return `RIVM_BOOT_START_3;
        endcase
    endfunction
    // one-cycle request, index 20 meaning the reset entry
    task automatic load(input int i, input logic [12:0] exp);
        @(posedge mclk);
        if (i == 20) rp <= 1'b1;
        else r[i] <= 1'b1;
        @(posedge mclk);
        rp <= 1'b0;
        r <= 20'h00000;
        #1;
        chk({12'h000, pl}, 13'h0001);
        chk(ad, exp);
        if (i < 20) chk({8'h00, ix}, 13'(i));
        else chk({8'h00, ix}, 13'h0000);
        repeat (8) @(posedge mclk);
    endtask
    task automatic ctrl(input logic u, input logic s);
        @(posedge mclk);
        cw <= 1'b1;
        cu <= u;
        cs <= s;
        @(posedge mclk);
        cw <= 1'b0;
    endtask
    // two requests at once, then the loser waits out the busy period
    task automatic prio();
        int n;
        dly <= 4'h4;
        @(posedge mclk);
        r[3] <= 1'b1;
        r[10] <= 1'b1;
        @(posedge mclk);
        r[3] <= 1'b0;
        #1;
        chk({8'h00, ix}, 13'h0003);
        repeat (3) begin
            @(posedge mclk);
            #1;
            chk({12'h000, pl}, 13'h0000);
        end
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (pl !== 1'b1 && n < 12);
        chk({12'h000, pl}, 13'h0001);
        chk(ad, 13'h0016);
        @(posedge mclk);
        r <= 20'h00000;
        dly <= 4'h1;
        repeat (10) @(posedge mclk);
    endtask
    // with interrupts disabled a request never fetches its vector
    task automatic gate();
        @(posedge mclk);
        gie <= 1'b0;
        r[5] <= 1'b1;
        repeat (4) begin
            @(posedge mclk);
            #1;
            chk({12'h000, pl}, 13'h0000);
        end
        @(posedge mclk);
        r <= 20'h00000;
        gie <= 1'b1;
    endtask
    // select change: accepted in the window, refused after or without it
    task automatic unlock();
        ctrl(1'b1, 1'b0);
        #1;
        chk({12'h000, unl}, 13'h0001);
        ctrl(1'b0, 1'b1);
        repeat (2) @(posedge mclk);
        #1;
        chk({12'h000, sel}, 13'h0001);
        ctrl(1'b1, 1'b1);
        repeat (6) @(posedge mclk);
        #1;
        chk({12'h000, unl}, 13'h0000);
        ctrl(1'b0, 1'b0);
        ctrl(1'b0, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        chk({12'h000, sel}, 13'h0001);
    endtask
    initial begin
        {resetn, rp, cw, cu, cs, r, sz} = '0;
        {fuse, gie} = 2'b11;
        dly = 4'h1;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        load(20, 13'h0000);
        for (int i = 0; i < 20; i++) begin
            load(i, 13'h0002 + 13'(2 * i));
        end
        prio();
        gate();
        unlock();
        load(1, bs(0) + 13'h0004);
        for (int c = 0; c < 4; c++) begin
            @(posedge mclk);
            fuse <= 1'b0;
            sz <= 2'(c);
            repeat (4) @(posedge mclk);
            load(20, bs(c));
            load(0, bs(c) + 13'h0002);
            load(19, bs(c) + 13'h0028);
        end
        ctrl(1'b1, 1'b0);
        ctrl(1'b0, 1'b0);
        repeat (2) @(posedge mclk);
        load(17, 13'h0024);
        load(20, bs(3));
        end_of_test();
    end
endmodule
